// >>> logic/gmoc_pkg.sv
// Package: register map, field layout and codes for the calibration registers
package gmoc_pkg;
  localparam logic [7:0] COL_DC_OFFSET_ADDR = 8'h20;
  localparam logic [7:0] GAIN_MODE_ADDR     = 8'h22;
  localparam logic [7:0] FINAL_OFFSET_ADDR  = 8'h23;
  localparam logic [7:0] COL_BANK_BASE_ADDR = 8'h80;
  localparam logic [7:0] COL_BANK_LAST_ADDR = 8'hBF;
  localparam logic [7:0] COL_DC_OFFSET_RST  = 8'h00;
  localparam logic [7:0] GAIN_MODE_RST      = 8'h00;
  localparam logic [7:0] FINAL_OFFSET_RST   = 8'h00;
  localparam logic [5:0] COL_BANK_RST       = 6'h00;
  localparam int         COL_BANK_DEPTH     = 64;
  localparam int         COL_IDX_W          = 6;
  localparam int         OFS_W              = 6;
  localparam int         OFS_SIGN_BIT       = 5;
  localparam int         WB_MODE_BIT        = 2;
  localparam int         EXP_MODE_HI        = 1;
  localparam int         EXP_MODE_LO        = 0;
  localparam int         FINAL_CODE_STEP    = 4;
  localparam int         FINAL_CODE_W       = 8;
  localparam int         COL_NUM_W          = 11;
  typedef enum logic [1:0] {
    GMOC_EXP_RAW,
    GMOC_EXP_LINEAR,
    GMOC_EXP_LINEAR2
  } gmoc_exp_mode_t;
endpackage

// >>> logic/gmoc_col_bank.sv
// Bank of 64 per-column offsets with registered read and column read ports
module gmoc_col_bank
  import gmoc_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // Write port
  input  wire logic                 wr_en,
  input  wire logic [COL_IDX_W-1:0] wr_idx,
  input  wire logic [OFS_W-1:0]     wr_data,
  // Register read port
  input  wire logic [COL_IDX_W-1:0] rd_idx,
  output logic      [OFS_W-1:0]     rd_data,
  // Column read port
  input  wire logic [COL_IDX_W-1:0] col_idx,
  output logic      [OFS_W-1:0]     col_data
);
  logic [OFS_W-1:0] mem_ff [COL_BANK_DEPTH];

  // Flops with reset so every entry starts at zero without a clear sweep
  genvar gi;
  generate
    for (gi = 0; gi < COL_BANK_DEPTH; gi++) begin : g_ent
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_ff[gi] <= COL_BANK_RST;
        end else if (clk_en && wr_en && wr_idx == COL_IDX_W'(gi)) begin
          mem_ff[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= COL_BANK_RST;
      col_data <= COL_BANK_RST;
    end else if (clk_en) begin
      rd_data  <= mem_ff[rd_idx];
      col_data <= mem_ff[col_idx];
    end
  end
endmodule

// >>> logic/gmoc_regs.sv
// Gain mode and offset calibration register bank with column selection
// Summary of operation
// - Gain mode bit 2 picks white-balance stepping: 0 raw, 1 linear.
// - Second linear mode uses only global gain A; otherwise A and B.
// - Column DC offset register resets to zero.
// - Sixty-four writable six-bit sign-magnitude column offsets, reset zero.
// - Each column uses the offset at index column modulo 64.
// - Address 0x80 serves column 0 up to 0xBF for column 63.
// - Final offset is six-bit sign-magnitude, bit 5 set means negative.
// - Each final offset unit shifts output four codes, span +/-124.
module gmoc_regs
  import gmoc_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // Register access from the serial port
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  output logic                         reg_rvalid,
  // Column stream
  input  wire logic [COL_NUM_W-1:0]    col_num,
  output logic      [OFS_W-1:0]        col_offset,
  // Decoded controls
  output logic                         wb_linear,
  output logic      [1:0]              exp_mode,
  output logic                         use_gain_b,
  output logic      [OFS_W-1:0]        col_dc_offset,
  output logic signed [FINAL_CODE_W-1:0] final_offset_codes
);
  logic [7:0] col_dc_ff, gain_mode_ff, final_ofs_ff;
  logic [7:0] rdata_ff;
  logic       rvalid_ff;
  logic       rd_bank_ff;
  logic [7:0] nxt_rdata;

  // Address decode
  wire hit_dc    = reg_addr == COL_DC_OFFSET_ADDR;
  wire hit_mode  = reg_addr == GAIN_MODE_ADDR;
  wire hit_final = reg_addr == FINAL_OFFSET_ADDR;
  wire hit_bank  = reg_addr >= COL_BANK_BASE_ADDR
                && reg_addr <= COL_BANK_LAST_ADDR;
  wire [COL_IDX_W-1:0] bank_idx = reg_addr[COL_IDX_W-1:0];
  wire [COL_IDX_W-1:0] col_mod  = col_num[COL_IDX_W-1:0];
  wire [OFS_W-1:0]     bank_rd;

  gmoc_col_bank u_bank (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .wr_en    (reg_wr && hit_bank),
    .wr_idx   (bank_idx),
    .wr_data  (reg_wdata[OFS_W-1:0]),
    .rd_idx   (bank_idx),
    .rd_data  (bank_rd),
    .col_idx  (col_mod),
    .col_data (col_offset)
  );

  // Upper unused bits are kept at zero and read back as zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_dc_ff    <= COL_DC_OFFSET_RST;
      gain_mode_ff <= GAIN_MODE_RST;
      final_ofs_ff <= FINAL_OFFSET_RST;
    end else if (clk_en && reg_wr) begin
      if (hit_dc)    col_dc_ff    <= {2'h0, reg_wdata[OFS_W-1:0]};
      if (hit_mode)  gain_mode_ff <= {5'h00, reg_wdata[2:0]};
      if (hit_final) final_ofs_ff <= {2'h0, reg_wdata[OFS_W-1:0]};
    end
  end

  assign nxt_rdata = hit_dc    ? col_dc_ff
                   : hit_mode  ? gain_mode_ff
                   : hit_final ? final_ofs_ff
                   : 8'h00;

  // Bank read data are one cycle late from the memory, so rvalid aligns both
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff   <= 8'h00;
      rvalid_ff  <= 1'b0;
      rd_bank_ff <= 1'b0;
    end else if (clk_en) begin
      rdata_ff   <= nxt_rdata;
      rvalid_ff  <= reg_rd;
      rd_bank_ff <= hit_bank;
    end
  end

  assign reg_rdata  = rd_bank_ff ? {2'h0, bank_rd} : rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // Mode decode
  assign wb_linear = gain_mode_ff[WB_MODE_BIT];
  assign exp_mode  = gain_mode_ff[EXP_MODE_HI] ? 2'(GMOC_EXP_LINEAR2)
                   : gain_mode_ff[EXP_MODE_LO] ? 2'(GMOC_EXP_LINEAR)
                   : 2'(GMOC_EXP_RAW);
  assign use_gain_b = !gain_mode_ff[EXP_MODE_HI];
  assign col_dc_offset = col_dc_ff[OFS_W-1:0];

  // Sign-magnitude to signed codes, four codes per unit
  wire [4:0] fmag = final_ofs_ff[4:0];
  wire signed [FINAL_CODE_W-1:0] fcodes =
    $signed({1'b0, fmag, 2'b00});
  assign final_offset_codes = final_ofs_ff[OFS_SIGN_BIT] ? -fcodes
                                                         : fcodes;

  a_dc_reset_zero: assert property (
    @(posedge ref_clk) $rose(rst_n) |-> col_dc_ff == 8'h00)
    else $error("dc not zero");
  a_wb_mode_bit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wb_linear == gain_mode_ff[2]) else $error("wb mode wrong");
  a_exp_mode_dec: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gain_mode_ff[1] |-> exp_mode == 2'(GMOC_EXP_LINEAR2)
    && !use_gain_b) else $error("exp mode wrong");
  a_gain_b_used: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exp_mode != 2'(GMOC_EXP_LINEAR2) |-> use_gain_b)
    else $error("gain b dropped");
  a_final_span: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    final_offset_codes <= 124 && final_offset_codes >= -124)
    else $error("final span");
  a_final_sign: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    final_ofs_ff[5] && fmag != 0 |-> final_offset_codes < 0)
    else $error("final sign");
  a_bank_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_wr && hit_bank ##1 clk_en && reg_rd && !reg_wr
    && $stable(reg_addr) ##1 1'b1
    |-> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)})
    else $error("bank write lost");
  a_col_select: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_wr && hit_bank && col_num[5:0] == reg_addr[5:0]
    ##1 clk_en && !reg_wr && $stable(col_num) ##1 1'b1
    |-> col_offset == $past(reg_wdata[5:0], 2))
    else $error("column pick wrong");
  a_bank_map: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    hit_bank |-> bank_idx == 6'(reg_addr - COL_BANK_BASE_ADDR))
    else $error("bank map");

  // Shadow of the last accepted write; feeds the checks only, so it
  // costs nothing once synthesis drops the unread flops
  logic [7:0] shd_addr_ff;
  logic [7:0] shd_data_ff;
  logic       shd_vld_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shd_addr_ff <= 8'h00;
      shd_data_ff <= 8'h00;
      shd_vld_ff  <= 1'b0;
    end else if (clk_en) begin
      shd_vld_ff <= reg_wr;
      if (reg_wr) begin
        shd_addr_ff <= reg_addr;
        shd_data_ff <= reg_wdata;
      end
    end
  end

  a_dc_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    shd_vld_ff && shd_addr_ff == COL_DC_OFFSET_ADDR
    |-> col_dc_ff == {2'h0, shd_data_ff[OFS_W-1:0]})
    else $error("dc write lost");
  a_mode_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    shd_vld_ff && shd_addr_ff == GAIN_MODE_ADDR
    |-> gain_mode_ff == {5'h00, shd_data_ff[2:0]})
    else $error("mode write lost");
  a_final_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    shd_vld_ff && shd_addr_ff == FINAL_OFFSET_ADDR
    |-> final_ofs_ff == {2'h0, shd_data_ff[OFS_W-1:0]})
    else $error("final write lost");

  // A low enable must look like a stopped clock to the host
  a_freeze_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> $stable(col_dc_ff) && $stable(gain_mode_ff)
    && $stable(final_ofs_ff) && $stable(col_offset)
    && $stable(reg_rvalid)) else $error("freeze broken");
  a_rvalid_rise: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_rd |=> reg_rvalid) else $error("no read answer");
  a_rvalid_drop: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !reg_rd |=> !reg_rvalid) else $error("stray answer");

  a_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_rd && !(hit_dc || hit_mode || hit_final || hit_bank)
    |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_upper_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    col_dc_ff[7:6] == 2'h0 && gain_mode_ff[7:3] == 5'h00
    && final_ofs_ff[7:6] == 2'h0) else $error("unused bits set");
  a_final_step: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !final_ofs_ff[OFS_SIGN_BIT]
    |-> final_offset_codes == FINAL_CODE_W'(FINAL_CODE_STEP * fmag))
    else $error("final step");
  a_reset_outputs: assert property (
    @(posedge ref_clk) $rose(rst_n)
    |-> !wb_linear && exp_mode == 2'(GMOC_EXP_RAW) && use_gain_b
    && final_offset_codes == '0) else $error("reset outputs");
  a_rd_after_wr: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_wr && (hit_dc || hit_final) ##1 clk_en && reg_rd
    && !reg_wr && $stable(reg_addr) ##1 1'b1
    |-> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)})
    else $error("read after write");

  c_linear2: cover property (@(posedge ref_clk) exp_mode == 2'(GMOC_EXP_LINEAR2));
  c_neg_final: cover property (@(posedge ref_clk) final_offset_codes < 0);
  c_bank_wr: cover property (@(posedge ref_clk) reg_wr && hit_bank);
  c_col_wrap: cover property (@(posedge ref_clk)
    clk_en && col_num[COL_NUM_W-1:COL_IDX_W] != 5'h00);
  c_frozen_wr: cover property (@(posedge ref_clk) !clk_en && reg_wr);
endmodule

// >>> dv/test_gmoc_regs.sv
// Self-checking bench for the calibration register bank
module test_gmoc_regs
  import gmoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          ref_clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          reg_wr = 1'b0;
  logic                          reg_rd = 1'b0;
  logic                          clk_en = 1'b1;
  logic [7:0]                    reg_addr = 8'h00;
  logic [7:0]                    reg_wdata = 8'h00;
  logic [7:0]                    reg_rdata;
  logic                          reg_rvalid;
  logic [COL_NUM_W-1:0]          col_num = '0;
  logic [OFS_W-1:0]              col_offset;
  logic [OFS_W-1:0]              col_dc_offset;
  logic                          wb_linear;
  logic                          use_gain_b;
  logic [1:0]                    exp_mode;
  logic signed [FINAL_CODE_W-1:0] final_offset_codes;
  logic [7:0]                    e;
  int                            i;
  int                            num_errors = 0;
  int                            n_tests = 0;

  gmoc_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .col_num(col_num), .col_offset(col_offset), .wb_linear(wb_linear),
    .exp_mode(exp_mode), .use_gain_b(use_gain_b),
    .col_dc_offset(col_dc_offset), .final_offset_codes(final_offset_codes));

  always #20 ref_clk = ~ref_clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Strobes stay up between like calls so no signal is set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
  endtask

  // Answer is expected one cycle on; a few spare cycles before giving up
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 4) begin
      num_errors++;
      complete_run();
    end else begin
      check(reg_rdata, exp);
    end
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    check({7'h00, wb_linear}, 8'h00);
    check({6'h00, exp_mode}, 8'h00);
    check({7'h00, use_gain_b}, 8'h01);
    check(final_offset_codes, 8'h00);
    rd(COL_DC_OFFSET_ADDR, COL_DC_OFFSET_RST);
    rd(GAIN_MODE_ADDR, GAIN_MODE_RST);
    rd(FINAL_OFFSET_ADDR, FINAL_OFFSET_RST);
    rd(COL_BANK_LAST_ADDR, {2'h0, COL_BANK_RST});
    // Unused upper bits are set on purpose and must read back clear
    for (i = 0; i < 8; i++) begin
      wr(GAIN_MODE_ADDR, 8'(i) | 8'hF8);
      rd(GAIN_MODE_ADDR, 8'(i));
      check({7'h00, wb_linear}, {7'h00, i[2]});
      check({6'h00, exp_mode}, i[1] ? 8'h02 : 8'(i[0]));
      check({7'h00, use_gain_b}, {7'h00, ~i[1]});
    end
    wr(COL_DC_OFFSET_ADDR, 8'hFF);
    rd(COL_DC_OFFSET_ADDR, 8'h3F);
    check({2'h0, col_dc_offset}, 8'h3F);
    wr(8'h21, 8'h5A);
    rd(8'h21, 8'h00);
    for (i = 0; i < 64; i++) begin
      wr(COL_BANK_BASE_ADDR + 8'(i), 8'hC0 | 8'((i * 5 + 3) & 63));
    end
    wr(8'hC0, 8'h00);
    rd(8'hC0, 8'h00);
    // Column numbers run far past 63 to show the wrap
    for (i = 0; i < 64; i++) begin
      e = 8'((i * 5 + 3) & 63);
      rd(COL_BANK_BASE_ADDR + 8'(i), e);
      col_num = 11'(i + 64 * (i % 32));
      @(posedge ref_clk);
      #1;
      check({2'h0, col_offset}, e);
    end
    // Write then read at once, with a column far past 63 on entry 5
    col_num = 11'h445;
    wr(8'h85, 8'h2A);
    rd(8'h85, 8'h2A);
    check({2'h0, col_offset}, 8'h2A);
    // A low clock enable must drop the write and hold final_offset_codes
    clk_en = 1'b0;
    wr(FINAL_OFFSET_ADDR, 8'h11);
    check(final_offset_codes, 8'h00);
    clk_en = 1'b1;
    rd(FINAL_OFFSET_ADDR, 8'h00);
    for (i = 0; i < 64; i++) begin
      wr(FINAL_OFFSET_ADDR, 8'(i));
      rd(FINAL_OFFSET_ADDR, 8'(i));
      e = 8'((i & 31) * 4);
      if (i[5]) e = -e;
      check(final_offset_codes, e);
    end
    complete_run();
  end
endmodule
